// [hw/wkc_pkg.sv]
// Behaviour
// RULE1 - reload value is high byte bits 15:8, low byte bits 7:0; interval value times tick
// RULE2 - host writes zero to reserved config bits
// RULE3 - coarse trim in config high bits 6:3 picks one of sixteen tune states
// RULE4 - tick divider code picks divide by 1,4,8,16,128,1024,8192,65536
// RULE5 - config low bit 6 enables rc oscillator, bit 5 crystal oscillator
// RULE6 - config low bit 4 selects rc tick source when 1, crystal when 0
// RULE7 - config low bit 3 keeps retention ram powered in sleep
// RULE8 - config low bit 0 arms wake-up on timer timeout
// RULE9 - device leaves sleep each time the wake timer expires
// RULE10 - wake counter counts hardware wake-ups and may interrupt host
// RULE11 - host programs a 16-bit wake limit
// RULE12 - every wake-up increments the wake count
// RULE13 - wake count greater than limit clears count to zero
// RULE14 - over limit with mask bit set raises host irq and enters off state
// RULE15 - host writes high byte directly followed by low byte
// RULE16 - timer starts from reload once both reload bytes written
// RULE17 - the four controller registers are write-only
// RULE18 - wake timer is a 16-bit down counter on the divided tick
// RULE19 - timer reloads on each timeout for periodic wake-ups
package wkc_pkg;
   localparam logic [9:0] ADDR_IRQ_MASK_LOW = 10'h100;
   localparam logic [9:0] ADDR_WAKE_COUNT_HI = 10'h102;
   localparam logic [9:0] ADDR_WAKE_COUNT_LO = 10'h103;
   localparam logic [9:0] ADDR_WAKE_LIMIT_HI = 10'h104;
   localparam logic [9:0] ADDR_WAKE_LIMIT_LO = 10'h105;
   localparam logic [9:0] ADDR_WAKE_CONFIG_HIGH = 10'h30c;
   localparam logic [9:0] ADDR_WAKE_CONFIG_LOW = 10'h30d;
   localparam logic [9:0] ADDR_WAKE_RELOAD_HIGH = 10'h30e;
   localparam logic [9:0] ADDR_WAKE_RELOAD_LOW = 10'h30f;
   localparam int WAKE_LIMIT_IRQ_BIT = 0;
   localparam int TRIM_MSB = 6;
   localparam int TRIM_LSB = 3;
   localparam int DIV_MSB = 2;
   localparam int RC_EN_BIT = 6;
   localparam int XTAL_EN_BIT = 5;
   localparam int SRC_SEL_BIT = 4;
   localparam int RAM_PWR_BIT = 3;
   localparam int ARM_BIT = 0;
   localparam logic [7:0] CFG_HIGH_RESET = 8'h68;
   localparam logic [7:0] CFG_LOW_RESET = 8'h00;
   localparam logic [3:0] TRIM_NOMINAL = 4'hd;
   localparam int SYNC_STAGES = 2;
   typedef enum logic [1:0] {
      WKC_SLEEP = 2'b00,
      WKC_AWAKE = 2'b01,
      WKC_OFF = 2'b10
   } wkc_state_t;
endpackage

// [hw/wkc_tick_div.sv]
`timescale 1ns/1ps
module wkc_tick_div
   import wkc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slowEdge,
   input wire logic [2:0] divSel,
   output logic tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } wkc_div_t;
   wkc_div_t state_reg, state_next;

   function automatic logic [15:0] wkc_div_last(input logic [2:0] sel);
      case (sel) // RULE4
         3'h0: wkc_div_last = 16'h0000;
         3'h1: wkc_div_last = 16'h0003;
         3'h2: wkc_div_last = 16'h0007;
         3'h3: wkc_div_last = 16'h000f;
         3'h4: wkc_div_last = 16'h007f;
         3'h5: wkc_div_last = 16'h03ff;
         3'h6: wkc_div_last = 16'h1fff;
         default: wkc_div_last = 16'hffff;
      endcase
   endfunction

   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (slowEdge) begin
         if (state_reg.cnt >= wkc_div_last(divSel)) begin
            state_next.cnt = 16'h0000;
            state_next.tick = 1'b1;
         end else begin
            state_next.cnt = state_reg.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign tick = state_reg.tick;

   property p_tick_needs_edge;
      @(posedge clk) disable iff (!rst_n) tick |-> $past(slowEdge);
   endproperty
   a_tick_needs_edge: assert property (p_tick_needs_edge) else $error("tick without slow edge"); // RULE4
endmodule

// [hw/wkc_wake_controller.sv]
`timescale 1ns/1ps
module wkc_wake_controller
   import wkc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rcOscClk,
   input wire logic xtalOscClk,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [9:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic sleepCmd,
   input wire logic wakeDone,
   output logic rcOscEnable,
   output logic crystalOscEnable,
   output logic [3:0] rcOscCoarseTrim,
   output logic retentionRamPower,
   output logic sleepState,
   output logic offState,
   output logic wakePulse,
   output logic hostIrqPin
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0] cfgHigh;
      logic [7:0] cfgLow;
      logic [7:0] reloadHigh;
      logic [15:0] reloadValue;
      logic [15:0] timer;
      logic running;
      logic [7:0] irqMask;
      logic [15:0] wakeCount;
      logic [15:0] wakeLimit;
      wkc_state_t fsm;
      logic wake;
      logic irq;
      logic [7:0] rdata;
      logic [SYNC_STAGES-1:0] rcSync;
      logic [SYNC_STAGES-1:0] xtSync;
      logic rcLast;
      logic xtLast;
   } wkc_ctl_t;
   wkc_ctl_t state_reg, state_next;
   logic tick;
   logic slowEdge;
   logic srcRc;

   ////////////////////////////////////////////////////////////////////////////
   // slow oscillators are foreign clocks: synchronise, then detect edges
   assign srcRc = state_reg.cfgLow[SRC_SEL_BIT]; // RULE6
   assign slowEdge = srcRc
      ? (state_reg.rcSync[1] & ~state_reg.rcLast & state_reg.cfgLow[RC_EN_BIT])
      : (state_reg.xtSync[1] & ~state_reg.xtLast & state_reg.cfgLow[XTAL_EN_BIT]);

   wkc_tick_div u_div (
      .clk(clk),
      .rst_n(rst_n),
      .slowEdge(slowEdge),
      .divSel(state_reg.cfgHigh[DIV_MSB:0]),
      .tick(tick)
   );

   always_comb begin
      state_next = state_reg;
      state_next.wake = 1'b0;
      state_next.rcSync = {state_reg.rcSync[0], rcOscClk};
      state_next.xtSync = {state_reg.xtSync[0], xtalOscClk};
      state_next.rcLast = state_reg.rcSync[1];
      state_next.xtLast = state_reg.xtSync[1];
      state_next.rdata = 8'h00;
      // down counter on the divided tick, reloading for periodic wake
      if (state_reg.running && tick) begin // RULE18
         if (state_reg.timer <= 16'h0001) begin
            state_next.timer = state_reg.reloadValue; // RULE19
            if (state_reg.cfgLow[ARM_BIT] && state_reg.fsm == WKC_SLEEP) begin // RULE8
               state_next.wake = 1'b1; // RULE9
               state_next.fsm = WKC_AWAKE;
            end
         end else begin
            state_next.timer = state_reg.timer - 16'h0001;
         end
      end
      // hardware wake counter; the fsm step runs one cycle after the wake
      case (state_reg.fsm)
         WKC_SLEEP: begin
         end
         WKC_AWAKE: begin
            if (state_reg.wake) begin
               if (state_reg.wakeCount + 16'h0001 > state_reg.wakeLimit) begin // RULE10
                  state_next.wakeCount = 16'h0000; // RULE13
                  if (state_reg.irqMask[WAKE_LIMIT_IRQ_BIT]) begin
                     state_next.irq = 1'b1; // RULE14
                     state_next.fsm = WKC_OFF;
                  end else begin
                     state_next.fsm = WKC_SLEEP;
                  end
               end else begin
                  state_next.wakeCount = state_reg.wakeCount + 16'h0001; // RULE12
                  state_next.fsm = WKC_SLEEP;
               end
            end else if (wakeDone) begin
               state_next.fsm = WKC_SLEEP;
            end
         end
         WKC_OFF: begin
            if (sleepCmd) begin
               state_next.fsm = WKC_SLEEP;
               state_next.irq = 1'b0;
            end
         end
         default: state_next.fsm = WKC_OFF;
      endcase
      // register writes; reserved bits stored as written, host keeps them zero
      if (regWrite) begin
         case (regAddr)
            ADDR_IRQ_MASK_LOW: state_next.irqMask = regWdata;
            ADDR_WAKE_COUNT_HI: state_next.wakeCount[15:8] = regWdata;
            ADDR_WAKE_COUNT_LO: state_next.wakeCount[7:0] = regWdata;
            ADDR_WAKE_LIMIT_HI: state_next.wakeLimit[15:8] = regWdata; // RULE11
            ADDR_WAKE_LIMIT_LO: state_next.wakeLimit[7:0] = regWdata;
            ADDR_WAKE_CONFIG_HIGH: state_next.cfgHigh = regWdata; // RULE2
            ADDR_WAKE_CONFIG_LOW: state_next.cfgLow = regWdata; // RULE15
            ADDR_WAKE_RELOAD_HIGH: state_next.reloadHigh = regWdata;
            ADDR_WAKE_RELOAD_LOW: begin
               state_next.reloadValue = {state_reg.reloadHigh, regWdata}; // RULE1
               state_next.timer = {state_reg.reloadHigh, regWdata}; // RULE16
               state_next.running = 1'b1;
            end
            default: ;
         endcase
      end
      if (state_reg.fsm == WKC_OFF && sleepCmd && !regWrite) begin
         state_next.wakeCount = state_next.wakeCount;
      end
      // config and reload registers are write-only and read as zero; mask, count and limit read back
      if (regRead) begin // RULE17
         case (regAddr)
            ADDR_IRQ_MASK_LOW: state_next.rdata = state_reg.irqMask;
            ADDR_WAKE_COUNT_HI: state_next.rdata = state_reg.wakeCount[15:8];
            ADDR_WAKE_COUNT_LO: state_next.rdata = state_reg.wakeCount[7:0];
            ADDR_WAKE_LIMIT_HI: state_next.rdata = state_reg.wakeLimit[15:8];
            ADDR_WAKE_LIMIT_LO: state_next.rdata = state_reg.wakeLimit[7:0];
            default: state_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.cfgHigh <= CFG_HIGH_RESET;
         state_reg.cfgLow <= CFG_LOW_RESET;
         state_reg.fsm <= WKC_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign regRdata = state_reg.rdata;
   assign rcOscEnable = state_reg.cfgLow[RC_EN_BIT]; // RULE5
   assign crystalOscEnable = state_reg.cfgLow[XTAL_EN_BIT]; // RULE5
   assign rcOscCoarseTrim = state_reg.cfgHigh[TRIM_MSB:TRIM_LSB]; // RULE3
   assign retentionRamPower = state_reg.cfgLow[RAM_PWR_BIT]; // RULE7
   assign sleepState = (state_reg.fsm == WKC_SLEEP);
   assign offState = (state_reg.fsm == WKC_OFF);
   assign wakePulse = state_reg.wake;
   assign hostIrqPin = state_reg.irq;

   ////////////////////////////////////////////////////////////////////////////
   property p_wake_on_expiry;
      @(posedge clk) disable iff (!rst_n)
         (state_reg.running && tick && state_reg.timer <= 16'h0001
          && state_reg.cfgLow[ARM_BIT] && sleepState) |=> wakePulse;
   endproperty
   a_wake_on_expiry: assert property (p_wake_on_expiry) else $error("no wake on expiry"); // RULE9

   property p_disarmed_no_wake;
      @(posedge clk) disable iff (!rst_n)
         !state_reg.cfgLow[ARM_BIT] && !regWrite |=> !wakePulse;
   endproperty
   a_disarmed_no_wake: assert property (p_disarmed_no_wake) else $error("wake while disarmed"); // RULE8

   property p_reload_on_expiry;
      @(posedge clk) disable iff (!rst_n)
         (state_reg.running && tick && state_reg.timer <= 16'h0001 && !regWrite)
         |=> state_reg.timer == $past(state_reg.reloadValue);
   endproperty
   a_reload_on_expiry: assert property (p_reload_on_expiry) else $error("no reload"); // RULE19

   property p_count_down;
      @(posedge clk) disable iff (!rst_n)
         (state_reg.running && tick && state_reg.timer > 16'h0001 && !regWrite)
         |=> state_reg.timer == $past(state_reg.timer) - 16'h0001;
   endproperty
   a_count_down: assert property (p_count_down) else $error("timer not decremented"); // RULE18

   property p_reload_write;
      @(posedge clk) disable iff (!rst_n)
         regWrite && regAddr == ADDR_WAKE_RELOAD_LOW
         |=> state_reg.timer == {$past(state_reg.reloadHigh), $past(regWdata)};
   endproperty
   a_reload_write: assert property (p_reload_write) else $error("reload not loaded"); // RULE16

   property p_count_inc;
      @(posedge clk) disable iff (!rst_n)
         (state_reg.fsm == WKC_AWAKE && state_reg.wake && !regWrite
          && state_reg.wakeCount + 16'h0001 <= state_reg.wakeLimit)
         |=> state_reg.wakeCount == $past(state_reg.wakeCount) + 16'h0001 ##1 1'b1;
   endproperty
   a_count_inc: assert property (p_count_inc) else $error("count not incremented"); // RULE12

   property p_count_clear;
      @(posedge clk) disable iff (!rst_n)
         (state_reg.fsm == WKC_AWAKE && state_reg.wake && !regWrite
          && state_reg.wakeCount + 16'h0001 > state_reg.wakeLimit)
         |=> state_reg.wakeCount == 16'h0000;
   endproperty
   a_count_clear: assert property (p_count_clear) else $error("count not cleared"); // RULE13

   property p_irq_off;
      @(posedge clk) disable iff (!rst_n)
         (state_reg.fsm == WKC_AWAKE && state_reg.wake
          && state_reg.wakeCount + 16'h0001 > state_reg.wakeLimit
          && state_reg.irqMask[WAKE_LIMIT_IRQ_BIT])
         |=> hostIrqPin && offState;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("no irq on limit"); // RULE14

   property p_write_only;
      @(posedge clk) disable iff (!rst_n)
         regRead && regAddr >= ADDR_WAKE_CONFIG_HIGH && regAddr <= ADDR_WAKE_RELOAD_LOW
         |=> regRdata == 8'h00;
   endproperty
   a_write_only: assert property (p_write_only) else $error("write-only reg readable"); // RULE17
endmodule

// [test/wkc_host_model.sv]
`timescale 1ns/1ps
module wkc_host_model
   import wkc_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] regRdata,
   output logic regWrite,
   output logic regRead,
   output logic [9:0] regAddr,
   output logic [7:0] regWdata
);
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 10'h000;
      regWdata = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // byte pairs go back to back, high first, so no other write slips between
   task automatic wr2(input logic [9:0] a, input logic [15:0] d);
      @(negedge clk);
      regAddr = a;
      regWdata = d[15:8];
      regWrite = 1'b1;
      @(negedge clk);
      regAddr = a + 10'h001;
      regWdata = d[7:0];
      @(negedge clk);
      regWrite = 1'b0;
      regWdata = ~d[7:0];
   endtask
   task automatic cfg(input logic [7:0] hi, input logic [7:0] lo);
      wr2(ADDR_WAKE_CONFIG_HIGH, {hi & 8'h7f, lo & 8'h79});
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      d = regRdata;
   endtask
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import wkc_pkg::*;
   logic clk, rst_n, rcOscClk, xtalOscClk, sleepCmd, regWrite, regRead;
   logic [9:0] regAddr;
   logic [7:0] regWdata, regRdata, d, e;
   logic rcOscEnable, crystalOscEnable, retentionRamPower, sleepState, offState;
   logic wakePulse, hostIrqPin;
   logic [3:0] rcOscCoarseTrim;
   int err_total, cmp_count, cyc, t0, seen;
   int divs[4] = '{1, 4, 8, 16};
   wkc_host_model i_wkc_host_model(.clk(clk), .regRdata(regRdata), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));
   wkc_wake_controller i_wkc_wake_controller(.clk(clk), .rst_n(rst_n), .rcOscClk(rcOscClk),
      .xtalOscClk(xtalOscClk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .sleepCmd(sleepCmd), .wakeDone(1'b0),
      .rcOscEnable(rcOscEnable), .crystalOscEnable(crystalOscEnable),
      .rcOscCoarseTrim(rcOscCoarseTrim), .retentionRamPower(retentionRamPower),
      .sleepState(sleepState), .offState(offState), .wakePulse(wakePulse),
      .hostIrqPin(hostIrqPin));
   ////////////////////////////////////////////////////////////////////////////////
   // slow clocks sped up to 16 and 24 system cycles to keep the run short
   initial clk = 1'b0;
   initial rcOscClk = 1'b0;
   initial xtalOscClk = 1'b0;
   always #12.5 clk = ~clk;
   always #200 rcOscClk = ~rcOscClk;
   always #300 xtalOscClk = ~xtalOscClk;
   always @(posedge clk) cyc <= cyc + 1;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] x);
      cmp_count++;
      if (s !== x) begin
         err_total++;
         $display("unexpected at %0t: saw %h wanted %h", $time, s, x);
      end
   endtask
   task automatic waitWake();
      int n;
      n = 0;
      @(negedge clk);
      while (wakePulse !== 1'b1) begin
         n++;
         if (n > 40000) begin
            err_total++;
            $display("unexpected at %0t: no wake pulse", $time);
            test_done();
         end
         @(negedge clk);
      end
   endtask
   task automatic period(input int x);
      waitWake();
      t0 = cyc;
      waitWake();
      chk(16'(cyc - t0), 16'(x));
   endtask
   task automatic sleepGo();
      @(negedge clk);
      sleepCmd = 1'b1;
      @(negedge clk);
      sleepCmd = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc = 0;
      err_total = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      sleepCmd = 1'b0;
      repeat (12) @(negedge clk);
      chk(rcOscCoarseTrim, TRIM_NOMINAL);
      chk(offState, 1'b1);
      rst_n = 1'b1;
      i_wkc_host_model.cfg(8'h38, 8'h59);
      repeat (2) @(negedge clk);
      chk(rcOscCoarseTrim, 4'h7);
      chk({rcOscEnable, crystalOscEnable, retentionRamPower}, 3'h5);
      for (int a = 0; a < 4; a++) begin
         i_wkc_host_model.rd(ADDR_WAKE_CONFIG_HIGH + 10'(a), d);
         chk(d, 8'h00);
      end
      $display("test config done");
      i_wkc_host_model.wr2(ADDR_IRQ_MASK_LOW - 10'h001, 16'h0001);
      i_wkc_host_model.wr2(ADDR_WAKE_LIMIT_HI, 16'h0002);
      i_wkc_host_model.wr2(ADDR_WAKE_COUNT_HI, 16'h0000);
      i_wkc_host_model.wr2(ADDR_WAKE_RELOAD_HIGH, 16'h0003);
      sleepGo();
      chk(sleepState, 1'b1);
      for (int i = 1; i < 4; i++) begin
         waitWake();
         if (i > 1)
            chk(16'(cyc - t0), 16'h0030);
         t0 = cyc;
         chk(sleepState, 1'b0);
         i_wkc_host_model.rd(ADDR_WAKE_COUNT_HI, d);
         i_wkc_host_model.rd(ADDR_WAKE_COUNT_LO, e);
         chk({d, e}, (i < 3) ? 16'(i) : 16'h0000);
         chk({hostIrqPin, offState, sleepState}, (i < 3) ? 3'h1 : 3'h6);
      end
      sleepGo();
      chk(hostIrqPin, 1'b0);
      i_wkc_host_model.wr2(ADDR_IRQ_MASK_LOW - 10'h001, 16'h0000);
      i_wkc_host_model.wr2(ADDR_WAKE_LIMIT_HI, 16'h0000);
      waitWake();
      repeat (2) @(negedge clk);
      chk({hostIrqPin, offState, sleepState}, 3'h1);
      i_wkc_host_model.rd(ADDR_WAKE_COUNT_HI, d);
      i_wkc_host_model.rd(ADDR_WAKE_COUNT_LO, e);
      chk({d, e}, 16'h0000);
      $display("test wake count done");
      i_wkc_host_model.wr2(ADDR_WAKE_LIMIT_HI, 16'hffff);
      i_wkc_host_model.wr2(ADDR_WAKE_RELOAD_HIGH, 16'h0002);
      for (int c = 0; c < 4; c++) begin
         i_wkc_host_model.cfg(8'h68 | 8'(c), 8'h59);
         period(32 * divs[c]);
      end
      $display("test divider done");
      i_wkc_host_model.cfg(8'h68, 8'h29);
      repeat (2) @(negedge clk);
      chk({rcOscEnable, crystalOscEnable, retentionRamPower}, 3'h3);
      period(48);
      i_wkc_host_model.cfg(8'h68, 8'h28);
      seen = 0;
      repeat (400) begin
         @(negedge clk);
         if (wakePulse === 1'b1)
            seen++;
      end
      chk(16'(seen), 16'h0000);
      chk(sleepState, 1'b1);
      $display("test source and arm done");
      test_done();
   end
endmodule
